// file: logic/tcm_pkg.sv
// Purpose: shared constants and carriers for the connection memory map block
// Assumes: 14-bit host word address, 16-bit data
// Notes: field positions of the low connection word and address split
package tcm_pkg;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 16;
  localparam int SPACE_BIT = 13;
  localparam int STRM_HI = 12;
  localparam int STRM_LO = 8;
  localparam int CHAN_HI = 7;
  localparam int CHAN_LO = 0;
  // control register select field values
  localparam logic [1:0] SEL_DATA = 2'h0;
  localparam logic [1:0] SEL_CW_LOW = 2'h1;
  localparam logic [1:0] SEL_CW_HIGH = 2'h2;
  // low connection word fields
  localparam int CW_CONV_BIT = 15;
  localparam int CW_VDLY_BIT = 14;
  localparam int CW_SS_HI = 13;
  localparam int CW_SS_LO = 9;
  localparam int CW_SC_HI = 8;
  localparam int CW_SC_LO = 1;
  localparam int CW_MODE_BIT = 0;
  localparam int CW_PCC_HI = 2;
  localparam int CW_PCC_LO = 1;
  localparam int CW_MSG_HI = 10;
  localparam int CW_MSG_LO = 3;
  localparam logic [15:0] CW_LOW_RST = 16'h0000;
  // stream rate codes and last usable channel per rate
  localparam logic [1:0] RATE_2M = 2'h0;
  localparam logic [1:0] RATE_4M = 2'h1;
  localparam logic [1:0] RATE_8M = 2'h2;
  localparam logic [1:0] RATE_16M = 2'h3;
  localparam logic [7:0] LAST_CH_2M = 8'h1F;
  localparam logic [7:0] LAST_CH_4M = 8'h3F;
  localparam logic [7:0] LAST_CH_8M = 8'h7F;
  localparam logic [7:0] LAST_CH_16M = 8'hFF;
  // per-channel special modes
  localparam logic [1:0] PCC_TRISTATE = 2'h0;
  localparam logic [1:0] PCC_MESSAGE = 2'h1;
  localparam logic [1:0] PCC_BERT = 2'h2;

  typedef enum logic [1:0] {
    TCM_NONE,
    TCM_REGS,
    TCM_MEM
  } tcm_target_t;

  typedef struct packed {
    logic [1:0] pcc;
    logic conv;
    logic var_dly;
    logic special;
    logic [4:0] src_stream;
    logic [7:0] src_chan;
    logic [7:0] msg;
  } tcm_chan_cfg_t;

  typedef struct packed {
    logic [15:0] rdata;
    logic ack;
    tcm_target_t target;
    logic range_err;
  } tcm_state_t;
endpackage : tcm_pkg

// file: logic/tcm_cw_decode.sv
// Purpose: interpret one low connection word
// Assumes: word as stored, global variable delay enable from control
// Notes: purely combinational
`timescale 1ns/1ps
module tcm_cw_decode
  import tcm_pkg::*;
(
  input wire logic [15:0] word_in,
  input wire logic var_global_in,
  output tcm_chan_cfg_t cfg_out
);
  always_comb begin
    cfg_out = '0;
    cfg_out.special = word_in[CW_MODE_BIT];
    cfg_out.conv = word_in[CW_CONV_BIT];
    if (!word_in[CW_MODE_BIT]) begin
      // delay choice; gated by global enable
      cfg_out.var_dly = word_in[CW_VDLY_BIT] & var_global_in;
      cfg_out.src_stream = word_in[CW_SS_HI:CW_SS_LO];
      cfg_out.src_chan = word_in[CW_SC_HI:CW_SC_LO];
    end else begin
      cfg_out.pcc = word_in[CW_PCC_HI:CW_PCC_LO];
      cfg_out.msg = word_in[CW_MSG_HI:CW_MSG_LO];
    end
  end
endmodule : tcm_cw_decode

// file: logic/tcm_map.sv
// Purpose: host address decode and low connection word store for a 32-stream switch
// Assumes: synchronous host strobes, one access per cycle, rates given per stream
// Notes: data memory and high word are external; this block steers and answers
// Notes: out-of-range channels drop writes and read zero, with a one-cycle error pulse
// Notes: the low word store is 8192 x 16 flops; reset clears it in one edge
// Notes: select code 3 reads return the memory port word
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tcm_map
  import tcm_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic acc_in,
  input wire logic wr_in,
  input wire logic [13:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic [1:0] mem_select_in,
  input wire logic variable_delay_global_enable_in,
  input wire logic [63:0] stream_rate_in,
  input wire logic [15:0] reg_rdata_in,
  input wire logic [15:0] mem_rdata_in,
  input wire logic [4:0] look_stream_in,
  input wire logic [7:0] look_chan_in,
  output logic reg_sel_out,
  output logic data_mem_sel_out,
  output logic cw_high_sel_out,
  output logic [4:0] mem_stream_out,
  output logic [7:0] mem_chan_out,
  output logic [15:0] rdata_out,
  output logic ack_out,
  output logic range_err_out,
  output tcm_chan_cfg_t look_cfg_out
);
  // where the registered read data comes from
  typedef enum logic [2:0] {
    RSRC_IDLE,
    RSRC_REGS,
    RSRC_OUT_OF_RANGE,
    RSRC_LOW_WORD,
    RSRC_MEM_PORT
  } tcm_rsrc_t;

  tcm_state_t st_r;
  tcm_state_t st_nxt;
  logic [15:0] cw_low_r [0:31][0:255];
  logic in_mem;
  logic [4:0] strm;
  logic [7:0] chan;
  logic [7:0] last_ch;
  logic chan_ok;
  logic cw_low_wr;

  // one limit per stream, indexed by stream number
  logic [31:0][7:0] stream_last_ch;
  logic [31:0] bank_wr;
  logic mem_acc;
  logic mem_ok;
  logic pick_data;
  logic pick_low;
  logic pick_high;
  tcm_rsrc_t rsrc;
  logic [15:0] low_rd;
  logic [15:0] look_word;

  //////////////////////////////////////////////////////////////////////////////
  // memory space on msb
  assign in_mem = addr_in[SPACE_BIT];
  assign strm = addr_in[STRM_HI:STRM_LO];
  assign chan = addr_in[CHAN_HI:CHAN_LO];

  // every limit is ready before the address arrives; only one mux sits in the path
  always_comb begin
    stream_last_ch = '0;
    for (int s = 0; s < 32; s++) begin
      // rate codes cover all four values, so no default is needed
      unique case (stream_rate_in[2*s +: 2])
        RATE_2M: stream_last_ch[s] = LAST_CH_2M;
        RATE_4M: stream_last_ch[s] = LAST_CH_4M;
        RATE_8M: stream_last_ch[s] = LAST_CH_8M;
        RATE_16M: stream_last_ch[s] = LAST_CH_16M;
      endcase
    end
  end

  assign last_ch = stream_last_ch[strm];
  assign chan_ok = chan <= last_ch;

  assign reg_sel_out = acc_in & ~in_mem;

  assign mem_acc = acc_in & in_mem;
  assign mem_ok = mem_acc & chan_ok;

  assign pick_data = mem_select_in == SEL_DATA;
  assign pick_low = mem_select_in == SEL_CW_LOW;
  assign pick_high = mem_select_in == SEL_CW_HIGH;
  // select code 3 names no memory; its reads go to the memory port
  // memory-port selects need an in-range channel
  assign data_mem_sel_out = mem_ok & pick_data;
  assign cw_high_sel_out = mem_ok & pick_high;
  assign cw_low_wr = mem_ok & wr_in & pick_low;
  assign mem_stream_out = strm;
  assign mem_chan_out = chan;

  // one write enable per stream bank
  always_comb begin
    bank_wr = '0;
    bank_wr[strm] = cw_low_wr;
  end

  //////////////////////////////////////////////////////////////////////////////
  // unused channel slots read zero and drop writes, so stale entries never switch
  always_comb begin
    if (!acc_in || wr_in) begin
      rsrc = RSRC_IDLE;
    end else if (!in_mem) begin
      rsrc = RSRC_REGS;
    end else if (!chan_ok) begin
      rsrc = RSRC_OUT_OF_RANGE;
    end else if (pick_low) begin
      rsrc = RSRC_LOW_WORD;
    end else begin
      rsrc = RSRC_MEM_PORT;
    end
  end

  assign low_rd = cw_low_r[strm][chan];

  //////////////////////////////////////////////////////////////////////////////
  // read data is registered so the host sees it with the acknowledge
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = acc_in;
    st_nxt.range_err = mem_acc & ~chan_ok;
    st_nxt.target = TCM_NONE;
    if (acc_in && in_mem) begin
      st_nxt.target = TCM_MEM;
    end else if (acc_in) begin
      st_nxt.target = TCM_REGS;
    end

    // the default only catches codes that no branch produces
    unique case (rsrc)
      RSRC_IDLE: st_nxt.rdata = 16'h0000;
      RSRC_OUT_OF_RANGE: st_nxt.rdata = 16'h0000;
      RSRC_REGS: st_nxt.rdata = reg_rdata_in;
      RSRC_LOW_WORD: st_nxt.rdata = low_rd;
      // data memory, high word or select code 3 read
      RSRC_MEM_PORT: st_nxt.rdata = mem_rdata_in;
      default: st_nxt.rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // reset clears every slot so no channel starts from a stale source
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      for (int s = 0; s < 32; s++) begin
        for (int c = 0; c < 256; c++) begin
          cw_low_r[s][c] <= CW_LOW_RST;
        end
      end
    end else begin
      for (int s = 0; s < 32; s++) begin
        if (bank_wr[s]) begin
          cw_low_r[s][chan] <= wdata_in;
        end
      end
    end
  end

  // registered host answers
  assign rdata_out = st_r.rdata;
  assign ack_out = st_r.ack;
  assign range_err_out = st_r.range_err;

  //////////////////////////////////////////////////////////////////////////////
  // decode port reads its own slot, independent of host accesses
  assign look_word = cw_low_r[look_stream_in][look_chan_in];

  tcm_cw_decode tcm_cw_decode_inst (
    .word_in(look_word),
    .var_global_in(variable_delay_global_enable_in),
    .cfg_out(look_cfg_out)
  );
endmodule : tcm_map

// file: verif/tcm_far.sv
// Purpose: register and memory read side of tcm_map
// Assumes: same-cycle read answers
// Notes: address patterns expose stale data
`timescale 1ns/1ps
module tcm_far (
  input wire logic [13:0] addr_in,
  output logic [15:0] reg_rdata_out,
  output logic [15:0] mem_rdata_out
);
  assign reg_rdata_out = {2'h3, addr_in};
  assign mem_rdata_out = ~{addr_in, 2'h1};
endmodule : tcm_far

// file: verif/tcm_map_props.sv
// Purpose: port checks of tcm_map
// Assumes: sync active-low reset
// Notes: bound below
`timescale 1ns/1ps
module tcm_map_props
  import tcm_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic acc_in,
  input wire logic [13:0] addr_in,
  input wire logic [1:0] mem_select_in,
  input wire logic variable_delay_global_enable_in,
  input wire logic [63:0] stream_rate_in,
  input wire logic reg_sel_out,
  input wire logic data_mem_sel_out,
  input wire logic cw_high_sel_out,
  input wire logic [4:0] mem_stream_out,
  input wire logic [7:0] mem_chan_out,
  input wire logic ack_out,
  input wire logic range_err_out,
  input wire tcm_chan_cfg_t look_cfg_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  logic [7:0] lim;
  logic mem;
  // 8-bit wrap gives 0xFF at top rate
  assign lim = (8'h20 << stream_rate_in[{addr_in[12:8], 1'b0} +: 2]) - 8'h01;
  assign mem = acc_in && addr_in[13];
  a_reg_space: assert property (reg_sel_out == (acc_in && !addr_in[13]))
    else $error("register select wrong");
  a_data_sel: assert property
    (data_mem_sel_out == (mem && mem_select_in == SEL_DATA && addr_in[7:0] <= lim))
    else $error("data memory select wrong");
  a_high_sel: assert property
    (cw_high_sel_out == (mem && mem_select_in == SEL_CW_HIGH && addr_in[7:0] <= lim))
    else $error("high word select wrong");
  a_addr_split: assert property ({mem_stream_out, mem_chan_out} == addr_in[12:0])
    else $error("address split wrong");
  a_ack_next: assert property (acc_in |=> ack_out)
    else $error("ack missing");
  a_range_hit: assert property (mem && addr_in[7:0] > lim |=> range_err_out)
    else $error("range error missing");
  a_range_clear: assert property (mem && addr_in[7:0] <= lim |=> !range_err_out)
    else $error("range error spurious");
  a_special_zero: assert property (look_cfg_out.special |-> !look_cfg_out.var_dly)
    else $error("special mode delay set");
  a_var_gate: assert property (look_cfg_out.var_dly |-> variable_delay_global_enable_in)
    else $error("variable delay ungated");
  cover property (mem && mem_select_in == SEL_CW_LOW);
  cover property (range_err_out);
  cover property (look_cfg_out.special);
endmodule : tcm_map_props
bind tcm_map tcm_map_props tcm_map_props_inst (.clock_in, .rst_b_in, .acc_in, .addr_in,
  .mem_select_in, .variable_delay_global_enable_in, .stream_rate_in, .reg_sel_out,
  .data_mem_sel_out, .cw_high_sel_out, .mem_stream_out, .mem_chan_out, .ack_out,
  .range_err_out, .look_cfg_out);

// file: verif/tcm_map_bench.sv
// Purpose: self-checking bench of tcm_map
// Assumes: inputs change at falling edge
// Notes: words modelled in an int array
`timescale 1ns/1ps
module tcm_map_bench;
  import tcm_pkg::*;
  logic clock_in, rst_b_in, acc_in, wr_in, ven, reg_sel, dsel, hsel, ack, rerr;
  logic [13:0] addr_in;
  logic [15:0] wdata_in, reg_rd, mem_rd, rdata;
  logic [1:0] sel;
  logic [63:0] rate;
  logic [4:0] lk_s, ms;
  logic [7:0] lk_c, mc;
  tcm_chan_cfg_t cfg;
  int n_mismatch = 0, comparisons = 0, seed = 75, m[8192];
  tcm_map tcm_map_inst (.clock_in(clock_in), .rst_b_in(rst_b_in), .acc_in(acc_in),
    .wr_in(wr_in), .addr_in(addr_in), .wdata_in(wdata_in), .mem_select_in(sel),
    .variable_delay_global_enable_in(ven), .stream_rate_in(rate), .reg_rdata_in(reg_rd),
    .mem_rdata_in(mem_rd), .look_stream_in(lk_s), .look_chan_in(lk_c), .reg_sel_out(reg_sel),
    .data_mem_sel_out(dsel), .cw_high_sel_out(hsel), .mem_stream_out(ms), .mem_chan_out(mc),
    .rdata_out(rdata), .ack_out(ack), .range_err_out(rerr), .look_cfg_out(cfg));
  tcm_far tcm_far_inst (.addr_in(addr_in), .reg_rdata_out(reg_rd), .mem_rdata_out(mem_rd));
  initial begin
    clock_in = 1'h0;
    forever #25 clock_in = ~clock_in;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: %h expected %h", $time, s, e);
    end
  endtask : chk
  task conclude();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  task do_reset();
    acc_in = 1'h0;
    rst_b_in = 1'h0;
    foreach (m[i]) m[i] = 0;
    repeat (16) @(negedge clock_in);
    rst_b_in = 1'h1;
  endtask : do_reset
  task run(input int n);
    int s, c, lim, x, idx, inr, mm;
    logic [15:0] w, e_rd;
    tcm_chan_cfg_t e;
    @(negedge clock_in);
    for (int i = 0; i < n; i++) begin
      acc_in = ($random(seed) & 3) != 0;
      {wr_in, ven} = 2'($random(seed));
      sel = 2'($random(seed));
      wdata_in = 16'($random(seed));
      s = $random(seed) & 7;
      lim = (32 << rate[2*s +: 2]) - 1;
      x = $random(seed) & 3;
      c = (x == 0 ? lim : x == 1 ? lim + 1 : $random(seed)) & 255;
      addr_in = {x != 3, s[4:0], c[7:0]};
      idx = s * 256 + c;
      {lk_s, lk_c} = 13'(idx);
      inr = c <= lim;
      mm = acc_in && addr_in[13];
      #1;
      chk(reg_sel, acc_in && !addr_in[13]);
      chk(dsel, mm && sel == SEL_DATA && inr);
      chk(hsel, mm && sel == SEL_CW_HIGH && inr);
      chk({ms, mc}, addr_in[12:0]);
      e_rd = 16'(!acc_in || wr_in ? 0 : !addr_in[13] ? {2'h3, addr_in} : !inr ? 0 :
        sel == SEL_CW_LOW ? m[idx] : ~{addr_in, 2'h1});
      if (mm && wr_in && inr && sel == SEL_CW_LOW) m[idx] = wdata_in;
      @(negedge clock_in);
      chk(ack, acc_in);
      chk(rdata, e_rd);
      chk(rerr, mm && !inr);
      w = 16'(m[idx]);
      e = '0;
      e.conv = w[15];
      e.special = w[0];
      if (w[0]) {e.pcc, e.msg} = {w[2:1], w[10:3]};
      else {e.var_dly, e.src_stream, e.src_chan} = {w[14] & ven, w[13:1]};
      chk(cfg, e);
    end
  endtask : run
  initial begin
    {acc_in, wr_in, ven, addr_in, wdata_in, sel, lk_s, lk_c} = '0;
    rate = {$random(seed), $random(seed)};
    rate[15:0] = 16'h1B1B;
    do_reset();
    run(300);
    do_reset();
    run(200);
    conclude();
  end
  initial begin
    #1000000;
    n_mismatch++;
    conclude();
  end
endmodule : tcm_map_bench
